// >>> rtl/afc_defs.vh
// constants for the adaptive feedback multi-device control block
`ifndef AFC_DEFS_VH
`define AFC_DEFS_VH
`define AFC_CLK_HZ 20000000
`define AFC_READY_US 5500
`define AFC_OTP_US 500
`define AFC_SHORT_US 4000
`define AFC_MON_US 100
`define AFC_ADDR_CHENA 32'h0000000C
`define AFC_ADDR_BAND 32'h0000009C
`define AFC_ADDR_STATUS 32'h00000100
`define AFC_ADDR_DIV 32'h00000104
`define AFC_ADDR_CTRL 32'h00000108
`define AFC_CHENA_RST 16'hFFFF
`define AFC_BAND_RST 8'h00
`define AFC_DIV_RST 8'h80
`define AFC_FBO_LOWER 2'h0
`define AFC_FBO_HOLD 2'h1
`define AFC_FBO_RAISE 2'h2
`define AFC_STRAP_SUP 2'h0
`define AFC_STRAP_RES 2'h1
`define AFC_STRAP_GND 2'h2
`endif

// >>> rtl/afc_multidevice_control.v
// adaptive feedback control, address straps, start-up and apb registers
`timescale 1ns/10ps
`default_nettype none
`include "afc_defs.vh"
module afc_multidevice_control #(
    parameter CHANNELS = 16,
    parameter CLK_HZ = `AFC_CLK_HZ,
    parameter READY_CYC = (`AFC_READY_US * (CLK_HZ / 1000)) / 1000,
    parameter OTP_CYC = (`AFC_OTP_US * (CLK_HZ / 1000) + 999) / 1000,
    parameter SHORT_CYC = (`AFC_SHORT_US * (CLK_HZ / 1000)) / 1000,
    parameter MON_CYC = (`AFC_MON_US * (CLK_HZ / 1000)) / 1000
) (
    // clock, reset, enable
    input wire clk_sys,
    input wire arst_n,
    input wire clkEn,
    // power and straps
    input wire enablePin,
    input wire logicSupplyOk,
    input wire roleStrap,
    input wire [1:0] address_strap_low,
    input wire [1:0] address_strap_high,
    input wire address_page_select,
    // analog comparator flags
    input wire [CHANNELS-1:0] headroomBelowLow,
    input wire [CHANNELS-1:0] headroomAboveHigh,
    input wire [CHANNELS-1:0] channelShortSeen,
    input wire feedbackAboveRaise,
    input wire feedbackAboveMax,
    input wire feedbackBelowLower,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // outputs to analog
    output reg [CHANNELS-1:0] channelDrive,
    output reg [1:0] bias_feedback_output,
    output reg [7:0] dividerStep,
    output reg [7:0] bandSetting,
    output reg [3:0] deviceAddress,
    output reg isMaster,
    output reg logicReady
);
    localparam ST_OFF = 3'h0;
    localparam ST_OTP = 3'h1;
    localparam ST_WAIT = 3'h2;
    localparam ST_RUN = 3'h3;
    localparam CNTW = 24;

    wire [CHANNELS-1:0] lowS;
    wire [CHANNELS-1:0] highS;
    wire [CHANNELS-1:0] shortS;
    wire [2:0] feedbackS;
    wire [4:0] pinS;

    // comparator flags are synchronised before use
    afc_sync #(.WIDTH(3*CHANNELS)) uSyncCh (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .asyncIn({headroomBelowLow, headroomAboveHigh, channelShortSeen}),
        .syncOut({lowS, highS, shortS})
    );
    afc_sync #(.WIDTH(8)) uSyncFb (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .asyncIn({feedbackAboveRaise, feedbackAboveMax, feedbackBelowLower,
                  enablePin, logicSupplyOk, 3'h0}),
        .syncOut({feedbackS, pinS})
    );
    wire enS = pinS[4];
    wire vccS = pinS[3];

    reg [2:0] state_q;
    reg [CNTW-1:0] seqCnt_q;
    reg [CNTW-1:0] monCnt_q;
    reg [CHANNELS-1:0] chEna_q;
    reg [CHANNELS-1:0] shutOff_q;
    reg addrTaken_q;
    reg upFlag_q;
    reg downFlag_q;
    reg [CNTW-1:0] shortCnt_q [0:CHANNELS-1];

    // feedback input detector
    wire inRaise = feedbackS[2] & ~feedbackS[1];
    wire inLower = feedbackS[0];

    wire activeAny = |chEna_q;
    wire anyLow = |(lowS & chEna_q & ~shutOff_q);
    wire allHigh = activeAny &&
        ((highS | ~chEna_q | shutOff_q) == {CHANNELS{1'b1}});
    wire wantRaise = upFlag_q | anyLow;
    wire wantLower = downFlag_q & allHigh & ~wantRaise;
    wire monTick = (monCnt_q == MON_CYC[CNTW-1:0] - 1'b1);
    wire running = (state_q == ST_RUN);

    // three-level strap pair to address
    reg [3:0] addrCode;
    always @* begin
        addrCode = {2'h0, address_strap_high} * 4'h3 +
            {2'h0, address_strap_low};
        if (address_strap_high == 2'h3 || address_strap_low == 2'h3) begin
            addrCode = 4'h8;
        end
        // code 8 is shared by both pages, also for an invalid strap
        if (address_page_select && addrCode != 4'h8) begin
            addrCode = addrCode + 4'h8;
        end
    end

    // start-up sequencer
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_OFF;
            seqCnt_q <= {CNTW{1'b0}};
            logicReady <= 1'b0;
        end else if (clkEn) begin
            case (state_q)
                ST_OFF: begin
                    logicReady <= 1'b0;
                    seqCnt_q <= {CNTW{1'b0}};
                    if (enS && vccS) begin
                        state_q <= ST_OTP;
                    end
                end
                ST_OTP: begin
                    seqCnt_q <= seqCnt_q + 1'b1;
                    if (seqCnt_q >= OTP_CYC[CNTW-1:0] - 1'b1) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    seqCnt_q <= seqCnt_q + 1'b1;
                    if (seqCnt_q >= READY_CYC[CNTW-1:0] - 1'b1) begin
                        state_q <= ST_RUN;
                        logicReady <= 1'b1;
                    end
                end
                ST_RUN: begin
                    logicReady <= 1'b1;
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
            if (!enS || !vccS) begin
                state_q <= ST_OFF;
                logicReady <= 1'b0;
            end
        end
    end

    // straps caught once, on the first cycle in ST_OTP after release of reset
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            addrTaken_q <= 1'b0;
            deviceAddress <= 4'h0;
            isMaster <= 1'b0;
        end else if (clkEn && !addrTaken_q && state_q == ST_OTP) begin
            addrTaken_q <= 1'b1;
            deviceAddress <= addrCode;
            isMaster <= ~roleStrap;
        end
    end

    // monitoring interval and decisions
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            monCnt_q <= {CNTW{1'b0}};
            upFlag_q <= 1'b0;
            downFlag_q <= 1'b0;
            dividerStep <= `AFC_DIV_RST;
            bias_feedback_output <= `AFC_FBO_HOLD;
        end else if (clkEn) begin
            upFlag_q <= inRaise;
            downFlag_q <= inLower & ~inRaise;
            if (!running) begin
                monCnt_q <= {CNTW{1'b0}};
                bias_feedback_output <= `AFC_FBO_HOLD;
            end else begin
                monCnt_q <= monTick ? {CNTW{1'b0}} : monCnt_q + 1'b1;
                if (!isMaster) begin
                    if (wantRaise) begin
                        bias_feedback_output <= `AFC_FBO_RAISE;
                    end else if (wantLower) begin
                        bias_feedback_output <= `AFC_FBO_LOWER;
                    end else begin
                        bias_feedback_output <= `AFC_FBO_HOLD;
                    end
                end else begin
                    // master: output held at the hold code, master steps the divider, slave does not step
                    bias_feedback_output <= `AFC_FBO_HOLD;
                    if (monTick) begin
                        if (wantRaise && dividerStep != 8'h00) begin
                            dividerStep <= dividerStep - 1'b1;
                        end else if (wantLower && dividerStep != 8'hFF) begin
                            dividerStep <= dividerStep + 1'b1;
                        end
                    end
                end
            end
        end
    end

    // per channel short timer and drive
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : gCh
            always @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    shortCnt_q[g] <= {CNTW{1'b0}};
                    shutOff_q[g] <= 1'b0;
                    channelDrive[g] <= 1'b0;
                end else if (clkEn) begin
                    if (!running) begin
                        shortCnt_q[g] <= {CNTW{1'b0}};
                        shutOff_q[g] <= 1'b0;
                    end else if (shortS[g] && chEna_q[g]) begin
                        if (shortCnt_q[g] >= SHORT_CYC[CNTW-1:0] - 1'b1) begin
                            shutOff_q[g] <= 1'b1;
                        end else begin
                            shortCnt_q[g] <= shortCnt_q[g] + 1'b1;
                        end
                    end else begin
                        shortCnt_q[g] <= {CNTW{1'b0}};
                    end
                    channelDrive[g] <= running & chEna_q[g] &
                        ~shutOff_q[g];
                end
            end
        end
    endgenerate

    // apb slave, answers in the access cycle
    wire apbSetup = psel & ~penable;
    wire apbWr = psel & penable & pwrite & pready;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            chEna_q <= `AFC_CHENA_RST;
            bandSetting <= `AFC_BAND_RST;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready <= apbSetup;
            pslverr <= 1'b0;
            if (apbWr) begin
                case (paddr)
                    `AFC_ADDR_CHENA: chEna_q <= pwdata[CHANNELS-1:0];
                    `AFC_ADDR_BAND: bandSetting <= pwdata[7:0];
                    default: begin
                    end
                endcase
            end
            if (apbSetup) begin
                prdata <= 32'h00000000;
                case (paddr)
                    `AFC_ADDR_CHENA: prdata[CHANNELS-1:0] <= chEna_q;
                    `AFC_ADDR_BAND: prdata[7:0] <= bandSetting;
                    `AFC_ADDR_STATUS: prdata <= {8'h00, shutOff_q[CHANNELS-1:0],
                        2'h0, upFlag_q, downFlag_q, deviceAddress};
                    `AFC_ADDR_DIV: prdata[7:0] <= dividerStep;
                    `AFC_ADDR_CTRL: prdata[4:0] <= {state_q, isMaster,
                        logicReady};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/afc_sync.v
// two-flop synchroniser for a bus of comparator flags
`timescale 1ns/10ps
`default_nettype none
module afc_sync #(
    parameter WIDTH = 1
) (
    input wire clk_sys,
    input wire arst_n,
    input wire clkEn,
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] meta_q;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end else if (clkEn) begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule
`default_nettype wire

// >>> verification/afc_fbi_model.sv
// feedback input level of a parallel device as comparator flags
`timescale 1ns/10ps
`default_nettype none
module afc_feedback_model (
    // 0: 0V, 1: 0.5V, 2: 1V, 3: above 1.2V
    input wire logic [1:0] feedbackLevel,
    // flags
    output logic feedbackAboveRaise,
    output logic feedbackAboveMax,
    output logic feedbackBelowLower
);
    assign feedbackAboveRaise = feedbackLevel >= 2'h2;
    assign feedbackAboveMax = feedbackLevel == 2'h3;
    assign feedbackBelowLower = feedbackLevel == 2'h0;
endmodule
`default_nettype wire

// >>> verification/afc_mdc_checker.sv
// port assertions for the multidevice control block
`timescale 1ns/10ps
`default_nettype none
`include "afc_defs.vh"
module afc_mdc_checker #(
    parameter CHANNELS = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // inputs
    input wire logic psel,
    input wire logic penable,
    input wire logic feedbackAboveRaise,
    input wire logic feedbackAboveMax,
    input wire logic feedbackBelowLower,
    input wire logic [CHANNELS-1:0] headroomAboveHigh,
    input wire logic [CHANNELS-1:0] headroomBelowLow,
    // outputs
    input wire logic pready,
    input wire logic [CHANNELS-1:0] channelDrive,
    input wire logic [1:0] bias_feedback_output,
    input wire logic [7:0] dividerStep,
    input wire logic [3:0] deviceAddress,
    input wire logic isMaster,
    input wire logic logicReady
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    apb_answer_a: assert property (
        psel && !penable |=> pready) else $error("no pready");
    ready_pulse_a: assert property (
        pready |=> !pready) else $error("pready held");
    slave_raise_a: assert property (
        (logicReady && !isMaster && feedbackAboveRaise
        && !feedbackAboveMax)[*8]
        |-> bias_feedback_output == `AFC_FBO_RAISE) else $error("no raise");
    slave_lower_a: assert property (
        (logicReady && !isMaster && feedbackBelowLower
        && !feedbackAboveRaise
        && (&headroomAboveHigh) && !(|headroomBelowLow)
        && (&channelDrive))[*8]
        |-> bias_feedback_output == `AFC_FBO_LOWER) else $error("no lower");
    master_pin_a: assert property (
        isMaster |-> bias_feedback_output == `AFC_FBO_HOLD)
        else $error("master pin moved");
    step_size_a: assert property (
        dividerStep != $past(dividerStep) |-> isMaster
        && (dividerStep == $past(dividerStep) + 8'h01
        || dividerStep == $past(dividerStep) - 8'h01))
        else $error("bad divider step");
    addr_kept_a: assert property (
        logicReady |=> $stable(deviceAddress)) else $error("address moved");
    drive_off_a: assert property (
        !logicReady && !$past(logicReady) |-> channelDrive == '0)
        else $error("drive before ready");
endmodule
bind afc_multidevice_control afc_mdc_checker #(.CHANNELS(CHANNELS)) chk (
    .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .feedbackAboveRaise(feedbackAboveRaise),
    .feedbackAboveMax(feedbackAboveMax),
    .feedbackBelowLower(feedbackBelowLower),
    .headroomAboveHigh(headroomAboveHigh),
    .headroomBelowLow(headroomBelowLow), .pready(pready),
    .channelDrive(channelDrive), .bias_feedback_output(bias_feedback_output),
    .dividerStep(dividerStep), .deviceAddress(deviceAddress),
    .isMaster(isMaster), .logicReady(logicReady));
`default_nettype wire

// >>> verification/afc_multidevice_control_test.sv
// self-checking bench for the multidevice control block
`timescale 1ns/10ps
`default_nettype none
`include "afc_defs.vh"
module afc_multidevice_control_test;
    localparam int RDYC = 16;
    logic clk_sys = 0, arst_n = 0, clkEn = 1, enablePin = 0, vccOk = 0;
    logic roleStrap = 0, pageSel = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, isMaster, logicReady, fRaise, fMax, fLow, err;
    logic [1:0] strapLo = 0, strapHi = 0, feedbackLevel = 1, biasOut;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [15:0] hrLow = 0, hrHigh = 0, shortSeen = 0, drive, mask, en;
    logic [7:0] dividerStep, bandSetting, d0;
    logic [3:0] deviceAddress;
    int seed = 99, nMismatch = 0, comparisons = 0, ch, i;
    always #25 clk_sys = ~clk_sys;
    afc_multidevice_control #(.OTP_CYC(8), .READY_CYC(RDYC), .SHORT_CYC(20),
        .MON_CYC(4)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn),
        .enablePin(enablePin), .logicSupplyOk(vccOk), .roleStrap(roleStrap),
        .address_strap_low(strapLo), .address_strap_high(strapHi),
        .address_page_select(pageSel), .headroomBelowLow(hrLow),
        .headroomAboveHigh(hrHigh), .channelShortSeen(shortSeen),
        .feedbackAboveRaise(fRaise), .feedbackAboveMax(fMax),
        .feedbackBelowLower(fLow),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .channelDrive(drive), .bias_feedback_output(biasOut),
        .dividerStep(dividerStep), .bandSetting(bandSetting),
        .deviceAddress(deviceAddress), .isMaster(isMaster),
        .logicReady(logicReady));
    afc_feedback_model far (.feedbackLevel(feedbackLevel),
        .feedbackAboveRaise(fRaise), .feedbackAboveMax(fMax),
        .feedbackBelowLower(fLow));
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
        if (nMismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic logic [31:0] supplyExp(input int lvl, input int mode);
        if (mode == 0 || lvl == 2)
            return `AFC_FBO_RAISE;
        if (mode == 1 && lvl == 0)
            return `AFC_FBO_LOWER;
        return `AFC_FBO_HOLD;
    endfunction
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys);
    endtask
    task powerUp(input logic role, input int lo, input int hi, input int pg);
        int k;
        arst_n <= 1'h0;
        enablePin <= 1'h0;
        vccOk <= 1'h0;
        roleStrap <= role;
        strapLo <= lo[1:0];
        strapHi <= hi[1:0];
        pageSel <= pg[0];
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'h1;
        repeat (5) @(posedge clk_sys);
        cmp(logicReady, 0);
        vccOk <= 1'h1;
        @(posedge clk_sys);
        enablePin <= 1'h1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (logicReady !== 1'h1 && k < 200);
        cmp(k >= RDYC && k <= RDYC + 4, 1);
        k = (pg && hi == 2 && lo == 2) ? 8 : hi * 3 + lo + pg * 8;
        cmp(deviceAddress, k);
        cmp(isMaster, !role);
    endtask
    task setIn(input int lvl, input int mode);
        ch = $unsigned($random(seed)) % 16;
        feedbackLevel <= lvl[1:0];
        hrLow <= (mode == 0) ? 16'h0001 << ch : 16'h0000;
        hrHigh <= (mode == 1) ? 16'hFFFF : ~(16'h0001 << ch);
        repeat (10) @(posedge clk_sys);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        nMismatch++;
        summarize;
    end
    initial begin
        for (i = 0; i < 18; i++) begin
            powerUp($random(seed), i % 3, (i / 3) % 3, i / 9);
            d0 = {4'h0, deviceAddress};
            strapLo <= ~strapLo;
            pageSel <= ~pageSel;
            repeat (4) @(posedge clk_sys);
            cmp(deviceAddress, d0);
        end
        $display("test address done");
        powerUp(1, 0, 0, 0);
        apb(0, `AFC_ADDR_CHENA, 0);
        cmp(rd, 32'h0000FFFF);
        apb(0, `AFC_ADDR_BAND, 0);
        cmp(rd, 32'h0);
        d0 = $random(seed);
        apb(1, `AFC_ADDR_BAND, {24'h0, d0});
        apb(0, `AFC_ADDR_BAND, 0);
        cmp(rd, {24'h0, d0});
        cmp(bandSetting, d0);
        apb(1, 32'h00000200, 32'hFFFFFFFF);
        cmp(err, 1);
        apb(0, `AFC_ADDR_CTRL, 0);
        cmp(rd[1:0], 2'h1);
        for (i = 0; i < 12; i++) begin
            setIn(i % 4, i / 4);
            cmp(biasOut, supplyExp(i % 4, i / 4));
        end
        cmp(dividerStep, 8'h80);
        $display("test slave done");
        mask = 16'h0001 << ch;
        shortSeen <= mask;
        repeat (10) @(posedge clk_sys);
        shortSeen <= 16'h0;
        repeat (5) @(posedge clk_sys);
        cmp(drive, 16'hFFFF);
        shortSeen <= mask;
        repeat (30) @(posedge clk_sys);
        cmp(drive, 16'(~mask));
        apb(0, `AFC_ADDR_STATUS, 0);
        cmp(rd[23:8], mask);
        shortSeen <= 16'h0;
        en = $random(seed);
        apb(1, `AFC_ADDR_CHENA, {16'h0, en});
        repeat (3) @(posedge clk_sys);
        cmp(drive, 16'(en & ~mask));
        $display("test short done");
        powerUp(0, 2, 2, 0);
        for (i = 0; i < 12; i++) begin
            setIn(i % 4, i / 4);
            d0 = dividerStep;
            repeat (16) @(posedge clk_sys);
            cmp(dividerStep < d0 ? `AFC_FBO_RAISE : dividerStep > d0 ?
                `AFC_FBO_LOWER : `AFC_FBO_HOLD, supplyExp(i % 4, i / 4));
            cmp(biasOut, `AFC_FBO_HOLD);
        end
        setIn(2, 1);
        // clock enable low must freeze the stepping divider
        clkEn <= 1'h0;
        @(posedge clk_sys);
        d0 = dividerStep;
        repeat (40) @(posedge clk_sys);
        cmp(dividerStep, d0);
        clkEn <= 1'h1;
        repeat (1100) @(posedge clk_sys);
        cmp(dividerStep, 8'h00);
        setIn(0, 1);
        repeat (1100) @(posedge clk_sys);
        cmp(dividerStep, 8'hFF);
        $display("test master done");
        summarize;
    end
endmodule
`default_nettype wire
